// ===== hw/ppc_cfg.svh
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// Register offsets
`define PPC_ADDR_STATUS 8'h00
`define PPC_ADDR_FET 8'h01
`define PPC_ADDR_BAL 8'h02
`define PPC_ADDR_OVR 8'h03
`define PPC_ADDR_MON 8'h04
`define PPC_ADDR_DCFG 8'h05
`define PPC_ADDR_CCFG 8'h06

// FET register fields
`define PPC_FET_CHG 0
`define PPC_FET_DCHG 1
`define PPC_FET_LDMON 2

// Override and scan register fields
`define PPC_OVR_DCHG_OC 0
`define PPC_OVR_SC 1
`define PPC_OVR_CHG_OC 2
`define PPC_OVR_DIE_HOT 3
`define PPC_OVR_EXT_HOT 4
`define PPC_OVR_ASD 5
`define PPC_OVR_BAO 6

// Status register fields
`define PPC_ST_DCHG_OC 0
`define PPC_ST_SC 1
`define PPC_ST_CHG_OC 2
`define PPC_ST_DIE_HOT 3
`define PPC_ST_EXT_HOT 4
`define PPC_ST_LOAD 5

// Discharge config fields
`define PPC_DCFG_DCHG_OC_THR 1:0
`define PPC_DCFG_DCHG_OC_DLY 4:2
`define PPC_DCFG_SC_THR 6:5
`define PPC_DCFG_SC_DLY 7

// Charge and time scale config fields
`define PPC_CCFG_CHG_OC_THR 1:0
`define PPC_CCFG_CHG_OC_DLY 4:2
`define PPC_CCFG_SCALE 7

// Reset values
`define PPC_RST_BYTE 8'h00
`define PPC_RST_BAL 6'h00
`define PPC_RST_MON 4'h0

// Monitor select code for external temperature
`define PPC_MON_EXT_TEMP 4'h9

// Timing
`define PPC_CLK_KHZ 125000
`define PPC_CYC_PER_MS (`PPC_CLK_KHZ / 1)
`define PPC_CYC_PER_US (`PPC_CLK_KHZ / 1000)
`define PPC_SCAN_PERIOD_MS 640
`define PPC_SCAN_ON_MS 5
`define PPC_SETTLE_MS 1
`define PPC_OC_UNIT_US 1000
`define PPC_SC_UNIT_US 100
`define PPC_SCALE_SHIFT 3
`define PPC_SC_SHIFT 4

`endif

// ===== hw/ppc_pkg.sv
package ppc_pkg;

   // Synchronised comparator levels
   typedef struct packed {
      logic load;
      logic therm_low;
      logic die_hot;
      logic chg_oc;
      logic sc;
      logic dchg_oc;
   } ppc_cmp_t;

   // Sticky fault flags
   typedef struct packed {
      logic ext_hot;
      logic die_hot;
      logic chg_oc;
      logic sc;
      logic dchg_oc;
   } ppc_flag_t;

endpackage : ppc_pkg

// ===== hw/ppc_top.sv
// Chosen here: the strobed register port.
`include "ppc_cfg.svh"

// Operation
// - Current held over threshold past delay trips FETs
// - Thresholds and delays come from 05H, 06H
// - Discharge overcurrent: FETs off, flag, clear enables
// - Discharge overcurrent override blocks automatic shutoff
// - Short circuit: FETs off, flag, clear enables
// - Short circuit override blocks automatic shutoff
// - Charge overcurrent: FETs off, flag, clear enables
// - Charge overcurrent override blocks automatic shutoff
// - Overridden faults still flag, FETs untouched
// - Current fault flags drive thermistor bias high
// - Host may re-enable FETs after current fault
// - Load monitor adds pulldown; status follows load
// - Auto scan biases thermistor 5ms per 640ms
// - Sample thermistor 1ms after bias turns on
// - External temperature select holds bias on
// - Scan disable stops periodic scan only
// - Always-on bit keeps bias permanently on
// - Over-temperature: FETs off, balancing off, flag
// - Over-temperature ignores FET enable and balance writes
// - Internal over-temperature override blocks shutdown
// - External over-temperature override blocks shutdown
module ppc_top
   import ppc_pkg::*;
#(
   parameter int SCAN_PERIOD_CYC = `PPC_SCAN_PERIOD_MS * `PPC_CYC_PER_MS,
   parameter int SCAN_ON_CYC = `PPC_SCAN_ON_MS * `PPC_CYC_PER_MS,
   parameter int SETTLE_CYC = `PPC_SETTLE_MS * `PPC_CYC_PER_MS,
   parameter int OC_UNIT_CYC = `PPC_OC_UNIT_US * `PPC_CYC_PER_US,
   parameter int SC_UNIT_CYC = `PPC_SC_UNIT_US * `PPC_CYC_PER_US
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Comparator results from the analog side
   input wire logic dchg_oc_cmp,
   input wire logic sc_cmp,
   input wire logic chg_oc_cmp,
   input wire logic die_hot_cmp,
   input wire logic therm_low_cmp,
   input wire logic load_cmp,
   // Threshold selects to the analog side
   output logic [1:0] dchg_oc_thr_sel,
   output logic [1:0] sc_thr_sel,
   output logic [1:0] chg_oc_thr_sel,
   // Drives
   output logic charge_switch_enable,
   output logic discharge_switch_enable,
   output logic load_pulldown_en,
   output logic thermistor_bias_output,
   output logic [5:0] cell_balance_en,
   output logic [3:0] monitor_select_field
);

   function automatic logic [31:0] dly_cyc(input logic [2:0] sel, input logic scale);
      logic [31:0] base;
      base = 32'(OC_UNIT_CYC) << sel;
      dly_cyc = scale ? (base << `PPC_SCALE_SHIFT) : base;
   endfunction : dly_cyc

   // Synchroniser
   ppc_cmp_t s1_q, s1_d, s2_q;

   always_comb begin
      s1_d = '{load: load_cmp, therm_low: therm_low_cmp, die_hot: die_hot_cmp,
               chg_oc: chg_oc_cmp, sc: sc_cmp, dchg_oc: dchg_oc_cmp};
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else if (ce) begin
         s1_q <= s1_d;
         s2_q <= s1_q;
      end
   end

   // Register state
   logic [7:0] fet_q, fet_d;
   logic [5:0] bal_q, bal_d;
   logic [7:0] ovr_q, ovr_d;
   logic [3:0] mon_q, mon_d;
   logic [7:0] dcfg_q, dcfg_d;
   logic [7:0] ccfg_q, ccfg_d;
   logic [7:0] rdata_q, rdata_d;
   ppc_flag_t flag_q, flag_d;
   logic load_q, load_d;

   // Fault qualification
   logic [31:0] cnt_q [3];
   logic [31:0] cnt_d [3];
   logic [31:0] lim [3];
   logic [2:0] cur_cmp;
   logic [2:0] trip;
   logic [2:0] cur_ovr;
   logic auto_off;

   always_comb begin
      lim[0] = dly_cyc(dcfg_q[`PPC_DCFG_DCHG_OC_DLY], ccfg_q[`PPC_CCFG_SCALE]);
      lim[1] = dcfg_q[`PPC_DCFG_SC_DLY] ? (32'(SC_UNIT_CYC) << `PPC_SC_SHIFT)
                                        : 32'(SC_UNIT_CYC);
      lim[2] = dly_cyc(ccfg_q[`PPC_CCFG_CHG_OC_DLY], ccfg_q[`PPC_CCFG_SCALE]);
      cur_cmp = {s2_q.chg_oc, s2_q.sc, s2_q.dchg_oc};
      cur_ovr = {ovr_q[`PPC_OVR_CHG_OC], ovr_q[`PPC_OVR_SC], ovr_q[`PPC_OVR_DCHG_OC]};
      for (int i = 0; i < 3; i++) begin
         trip[i] = cur_cmp[i] && (cnt_q[i] == lim[i] - 32'd1);
         if (!cur_cmp[i]) begin
            cnt_d[i] = '0;
         end else if (cnt_q[i] < lim[i]) begin
            cnt_d[i] = cnt_q[i] + 32'd1;
         end else begin
            cnt_d[i] = cnt_q[i];
         end
      end
      auto_off = |(trip & ~cur_ovr);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            cnt_q[i] <= '0;
         end
      end else if (ce) begin
         for (int i = 0; i < 3; i++) begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end

   // Thermistor scan and sampling
   logic [31:0] scan_q, scan_d;
   logic [31:0] settle_q, settle_d;
   logic xt_hot_q, xt_hot_d;
   logic bias_q, bias_d;
   logic bias_req;

   always_comb begin
      if (ovr_q[`PPC_OVR_ASD]) begin
         scan_d = '0;
      end else if (scan_q >= 32'(SCAN_PERIOD_CYC - 1)) begin
         scan_d = '0;
      end else begin
         scan_d = scan_q + 32'd1;
      end
      bias_req = ovr_q[`PPC_OVR_BAO]
               || (mon_q == `PPC_MON_EXT_TEMP)
               || (!ovr_q[`PPC_OVR_ASD] && scan_q < 32'(SCAN_ON_CYC));
      bias_d = bias_req || flag_q.dchg_oc || flag_q.sc || flag_q.chg_oc;
      if (!bias_q) begin
         settle_d = '0;
      end else if (settle_q < 32'(SETTLE_CYC)) begin
         settle_d = settle_q + 32'd1;
      end else begin
         settle_d = settle_q;
      end
      xt_hot_d = (settle_q >= 32'(SETTLE_CYC)) ? s2_q.therm_low : xt_hot_q;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scan_q <= '0;
         settle_q <= '0;
         xt_hot_q <= 1'b0;
         bias_q <= 1'b0;
      end else if (ce) begin
         scan_q <= scan_d;
         settle_q <= settle_d;
         xt_hot_q <= xt_hot_d;
         bias_q <= bias_d;
      end
   end

   // Over-temperature hold
   logic hold;
   logic wr_fet;
   logic wr_bal;

   always_comb begin
      hold = (s2_q.die_hot && !ovr_q[`PPC_OVR_DIE_HOT])
          || (xt_hot_q && !ovr_q[`PPC_OVR_EXT_HOT]);
      wr_fet = reg_wr && (reg_addr == `PPC_ADDR_FET);
      wr_bal = reg_wr && (reg_addr == `PPC_ADDR_BAL);
   end

   // Register writes, flags and read data
   always_comb begin
      fet_d = fet_q;
      bal_d = bal_q;
      ovr_d = ovr_q;
      mon_d = mon_q;
      dcfg_d = dcfg_q;
      ccfg_d = ccfg_q;
      flag_d = flag_q;
      rdata_d = 8'h00;
      if (wr_fet) begin
         fet_d[`PPC_FET_LDMON] = reg_wdata[`PPC_FET_LDMON];
         if (!hold) begin
            fet_d[`PPC_FET_CHG] = reg_wdata[`PPC_FET_CHG];
            fet_d[`PPC_FET_DCHG] = reg_wdata[`PPC_FET_DCHG];
         end
      end
      if (wr_bal && !hold) begin
         bal_d = reg_wdata[5:0];
      end
      if (reg_wr && reg_addr == `PPC_ADDR_OVR) begin
         ovr_d = {1'b0, reg_wdata[6:0]};
      end
      if (reg_wr && reg_addr == `PPC_ADDR_MON) begin
         mon_d = reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == `PPC_ADDR_DCFG) begin
         dcfg_d = reg_wdata;
      end
      if (reg_wr && reg_addr == `PPC_ADDR_CCFG) begin
         ccfg_d = reg_wdata;
      end
      if (reg_wr && reg_addr == `PPC_ADDR_STATUS) begin
         flag_d = flag_q & ~ppc_flag_t'(reg_wdata[4:0]);
      end
      flag_d.dchg_oc = flag_d.dchg_oc | trip[0];
      flag_d.sc = flag_d.sc | trip[1];
      flag_d.chg_oc = flag_d.chg_oc | trip[2];
      flag_d.die_hot = flag_d.die_hot | s2_q.die_hot;
      flag_d.ext_hot = flag_d.ext_hot | xt_hot_q;
      if (auto_off || hold) begin
         fet_d[`PPC_FET_CHG] = 1'b0;
         fet_d[`PPC_FET_DCHG] = 1'b0;
      end
      if (hold) begin
         bal_d = '0;
      end
      if (reg_rd) begin
         if (reg_addr == `PPC_ADDR_STATUS) begin
            rdata_d = {2'b00, load_q, flag_q};
         end else if (reg_addr == `PPC_ADDR_FET) begin
            rdata_d = fet_q;
         end else if (reg_addr == `PPC_ADDR_BAL) begin
            rdata_d = {2'b00, bal_q};
         end else if (reg_addr == `PPC_ADDR_OVR) begin
            rdata_d = ovr_q;
         end else if (reg_addr == `PPC_ADDR_MON) begin
            rdata_d = {4'h0, mon_q};
         end else if (reg_addr == `PPC_ADDR_DCFG) begin
            rdata_d = dcfg_q;
         end else if (reg_addr == `PPC_ADDR_CCFG) begin
            rdata_d = ccfg_q;
         end else begin
            rdata_d = 8'h00;
         end
      end
      load_d = fet_q[`PPC_FET_LDMON] && s2_q.load;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fet_q <= `PPC_RST_BYTE;
         bal_q <= `PPC_RST_BAL;
         ovr_q <= `PPC_RST_BYTE;
         mon_q <= `PPC_RST_MON;
         dcfg_q <= `PPC_RST_BYTE;
         ccfg_q <= `PPC_RST_BYTE;
         flag_q <= '0;
         rdata_q <= 8'h00;
         load_q <= 1'b0;
      end else if (ce) begin
         fet_q <= fet_d;
         bal_q <= bal_d;
         ovr_q <= ovr_d;
         mon_q <= mon_d;
         dcfg_q <= dcfg_d;
         ccfg_q <= ccfg_d;
         flag_q <= flag_d;
         rdata_q <= rdata_d;
         load_q <= load_d;
      end
   end

   // Outputs
   assign reg_rdata = rdata_q;
   assign dchg_oc_thr_sel = dcfg_q[`PPC_DCFG_DCHG_OC_THR];
   assign sc_thr_sel = dcfg_q[`PPC_DCFG_SC_THR];
   assign chg_oc_thr_sel = ccfg_q[`PPC_CCFG_CHG_OC_THR];
   assign charge_switch_enable = fet_q[`PPC_FET_CHG];
   assign discharge_switch_enable = fet_q[`PPC_FET_DCHG];
   assign load_pulldown_en = fet_q[`PPC_FET_LDMON];
   assign thermistor_bias_output = bias_q;
   assign cell_balance_en = bal_q;
   assign monitor_select_field = mon_q;

   // Checks
   AST_TRIP_OFF: assert property (@(posedge clk_sys) disable iff (rst)
      ce && auto_off |=> !charge_switch_enable && !discharge_switch_enable)
      else $error("FETs stay on after qualified current fault");

   AST_DCHG_OC_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
      ce && trip[0] |=> flag_q.dchg_oc)
      else $error("Discharge overcurrent flag not set");

   AST_SC_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
      ce && trip[1] && !ovr_q[`PPC_OVR_SC] |=> flag_q.sc && !discharge_switch_enable)
      else $error("Short circuit not handled");

   AST_CHG_OC_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
      ce && trip[2] && !ovr_q[`PPC_OVR_CHG_OC] |=> flag_q.chg_oc && !charge_switch_enable)
      else $error("Charge overcurrent not handled");

   AST_OVERRIDE: assert property (@(posedge clk_sys) disable iff (rst)
      ce && (trip & cur_ovr) != 3'b000 && (trip & ~cur_ovr) == 3'b000 && !hold && !wr_fet
      |=> $stable(fet_q[1:0]) && (flag_q != '0))
      else $error("Overridden fault changed FET control");

   AST_DCHG_OC_OVR: assert property (@(posedge clk_sys) disable iff (rst)
      ce && trip == 3'b001 && ovr_q[`PPC_OVR_DCHG_OC] && !hold && !wr_fet
      |=> $stable(fet_q))
      else $error("Discharge overcurrent override ignored");

   AST_BIAS_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
      ce && (flag_q.dchg_oc || flag_q.sc || flag_q.chg_oc) |=> thermistor_bias_output)
      else $error("Bias not raised on current fault flag");

   AST_HOST_FET: assert property (@(posedge clk_sys) disable iff (rst)
      ce && wr_fet && !hold && !auto_off
      |=> fet_q[1:0] == $past(reg_wdata[1:0]))
      else $error("Host FET write not honoured");

   AST_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
      ce && !load_pulldown_en |=> !load_q)
      else $error("Load status set with monitor off");

   AST_SCAN_ON: assert property (@(posedge clk_sys) disable iff (rst)
      ce && !ovr_q[`PPC_OVR_ASD] && scan_q < 32'(SCAN_ON_CYC) |=> thermistor_bias_output)
      else $error("Scan window without bias");

   AST_SETTLE: assert property (@(posedge clk_sys) disable iff (rst)
      ce && settle_q < 32'(SETTLE_CYC) |=> $stable(xt_hot_q))
      else $error("Thermistor sampled before settling");

   AST_EXT_SEL: assert property (@(posedge clk_sys) disable iff (rst)
      ce && mon_q == `PPC_MON_EXT_TEMP |=> thermistor_bias_output)
      else $error("Bias off with external temperature selected");

   AST_SCAN_OFF: assert property (@(posedge clk_sys) disable iff (rst)
      ce && ovr_q[`PPC_OVR_ASD] |=> scan_q == 32'd0)
      else $error("Scan runs while disabled");

   AST_ALWAYS_ON: assert property (@(posedge clk_sys) disable iff (rst)
      ce && ovr_q[`PPC_OVR_BAO] |=> thermistor_bias_output)
      else $error("Always-on bias not applied");

   AST_OT_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
      ce && s2_q.die_hot |=> flag_q.die_hot)
      else $error("Internal over-temperature flag not set");

   AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      ce && hold |=> !charge_switch_enable && !discharge_switch_enable
      && cell_balance_en == 6'h00)
      else $error("Outputs not held off during over-temperature");

   AST_DIE_HOT_OVR: assert property (@(posedge clk_sys) disable iff (rst)
      ce && s2_q.die_hot && ovr_q[`PPC_OVR_DIE_HOT] && !xt_hot_q && !auto_off && wr_bal
      |=> cell_balance_en == $past(reg_wdata[5:0]))
      else $error("Internal over-temperature override ignored");

   AST_EXT_HOT_OVR: assert property (@(posedge clk_sys) disable iff (rst)
      ce && xt_hot_q && ovr_q[`PPC_OVR_EXT_HOT] && !s2_q.die_hot && wr_bal
      |=> cell_balance_en == $past(reg_wdata[5:0]))
      else $error("External over-temperature override ignored");

   AST_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
      ce && !s2_q.dchg_oc |=> cnt_q[0] == 32'd0)
      else $error("Delay counter not restarted");

   AST_DCFG: assert property (@(posedge clk_sys) disable iff (rst)
      ce && reg_wr && reg_addr == `PPC_ADDR_DCFG |=> dcfg_q == $past(reg_wdata))
      else $error("Discharge config write lost");

endmodule : ppc_top

// ===== tb/ppc_host.sv
module ppc_host (
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // One-cycle write strobe
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   // One-cycle read strobe, data taken in the following cycle
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask : rd

   // Re-enable the FETs only after the load has gone
   task recover(output logic ok);
      logic [7:0] st;
      ok = 1'b0;
      wr(8'h01, 8'h04);
      for (int i = 0; i < 20 && !ok; i++) begin
         rd(8'h00, st);
         ok = (st[5] === 1'b0);
      end
      if (ok) begin
         wr(8'h01, 8'h07);
      end
   endtask : recover
endmodule : ppc_host

// ===== tb/tb.sv
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end

module tb import ppc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, e_mon;
   logic reg_wr, reg_rd, rd_pend = 1'b0;
   logic [2:0] cur_cmp = 3'h0;
   logic die_hot_cmp = 1'b0, therm_low_cmp = 1'b0, load_cmp = 1'b0;
   logic [1:0] dchg_oc_thr_sel, sc_thr_sel, chg_oc_thr_sel;
   logic charge_switch_enable, discharge_switch_enable, load_pulldown_en;
   logic thermistor_bias_output;
   logic [5:0] cell_balance_en;
   logic [3:0] monitor_select_field;
   logic [31:0] seed = 32'hD968;
   logic [7:0] q[$];
   int n_mismatch = 0, tests_run = 0, cyc = 0;

   always #4 clk_sys = ~clk_sys;

   ppc_top #(.SCAN_PERIOD_CYC(200), .SCAN_ON_CYC(20), .SETTLE_CYC(5), .OC_UNIT_CYC(4),
      .SC_UNIT_CYC(2)) dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dchg_oc_cmp(cur_cmp[0]), .sc_cmp(cur_cmp[1]), .chg_oc_cmp(cur_cmp[2]),
      .die_hot_cmp(die_hot_cmp), .therm_low_cmp(therm_low_cmp), .load_cmp(load_cmp),
      .dchg_oc_thr_sel(dchg_oc_thr_sel), .sc_thr_sel(sc_thr_sel),
      .chg_oc_thr_sel(chg_oc_thr_sel),
      .charge_switch_enable(charge_switch_enable),
      .discharge_switch_enable(discharge_switch_enable), .load_pulldown_en(load_pulldown_en),
      .thermistor_bias_output(thermistor_bias_output), .cell_balance_en(cell_balance_en),
      .monitor_select_field(monitor_select_field));

   ppc_host host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : tick

   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      q.push_back(e);
      host_u.rd(a, d);
   endtask : rd_chk

   task end_sim;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   // Read results are matched against the oldest note
   always @(negedge clk_sys) begin
      if (rd_pend && q.size() > 0) begin
         e_mon = q.pop_front();
         `CHK(reg_rdata, e_mon)
      end
      rd_pend = reg_rd;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end

   initial begin
      logic [7:0] bal;
      logic ok;
      int cnt;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values, unmapped address included
      for (int a = 0; a < 8; a++) rd_chk(8'(a), 8'h00);
      // Threshold selects follow the configuration bytes
      repeat (3) begin
         seed = lfsr(seed);
         host_u.wr(8'h05, seed[7:0]);
         host_u.wr(8'h06, seed[15:8]);
         rd_chk(8'h05, seed[7:0]);
         rd_chk(8'h06, seed[15:8]);
         `CHK(dchg_oc_thr_sel, seed[1:0])
         `CHK(sc_thr_sel, seed[6:5])
         `CHK(chg_oc_thr_sel, seed[9:8])
      end
      host_u.wr(8'h05, 8'h00);
      host_u.wr(8'h06, 8'h00);
      // Current faults, automatic and overridden
      for (int i = 0; i < 3; i++) for (int o = 0; o < 2; o++) begin
         host_u.wr(8'h03, 8'h20 | 8'(o << i));
         host_u.wr(8'h01, 8'h03);
         repeat (2) begin
            cur_cmp[i] <= 1'b1;
            repeat ((i == 1) ? 1 : 3) @(posedge clk_sys);
            cur_cmp[i] <= 1'b0;
            repeat (2) @(posedge clk_sys);
         end
         tick(4);
         `CHK(charge_switch_enable, 1'b1)
         `CHK(thermistor_bias_output, 1'b0)
         @(posedge clk_sys);
         cur_cmp[i] <= 1'b1;
         tick(12);
         `CHK({charge_switch_enable, discharge_switch_enable}, o ? 2'b11 : 2'b00)
         `CHK(thermistor_bias_output, 1'b1)
         rd_chk(8'h00, 8'(1 << i));
         rd_chk(8'h01, o ? 8'h03 : 8'h00);
         @(posedge clk_sys);
         cur_cmp[i] <= 1'b0;
         tick(4);
         host_u.wr(8'h00, 8'(1 << i));
         rd_chk(8'h00, 8'h00);
         `CHK(thermistor_bias_output, 1'b0)
      end
      // Load monitor and host re-enable after a host write turns the FETs off
      @(posedge clk_sys);
      load_cmp <= 1'b1;
      host_u.wr(8'h01, 8'h04);
      rd_chk(8'h00, 8'h20);
      `CHK(load_pulldown_en, 1'b1)
      fork
         host_u.recover(ok);
         begin
            tick(8);
            @(posedge clk_sys);
            load_cmp <= 1'b0;
         end
      join
      tick(2);
      `CHK(ok, 1'b1)
      `CHK({charge_switch_enable, discharge_switch_enable}, 2'b11)
      // Over-temperature, automatic and overridden
      for (int k = 3; k < 5; k++) for (int o = 0; o < 2; o++) begin
         seed = lfsr(seed);
         bal = {2'b00, seed[5:0]};
         host_u.wr(8'h03, 8'h20 | 8'(o << k));
         host_u.wr(8'h04, (k == 4) ? 8'h09 : 8'h00);
         host_u.wr(8'h01, 8'h03);
         host_u.wr(8'h02, bal);
         tick(1);
         `CHK(cell_balance_en, bal[5:0])
         @(posedge clk_sys);
         die_hot_cmp <= (k == 3);
         therm_low_cmp <= (k == 4);
         tick(15);
         host_u.wr(8'h01, 8'h03);
         host_u.wr(8'h02, 8'h3F);
         tick(1);
         `CHK({charge_switch_enable, discharge_switch_enable}, o ? 2'b11 : 2'b00)
         `CHK(cell_balance_en, o ? 6'h3F : 6'h00)
         `CHK(thermistor_bias_output, (k == 4) ? 1'b1 : 1'b0)
         `CHK(monitor_select_field, (k == 4) ? 4'h9 : 4'h0)
         rd_chk(8'h00, 8'(1 << k));
         @(posedge clk_sys);
         die_hot_cmp <= 1'b0;
         therm_low_cmp <= 1'b0;
         tick(12);
         host_u.wr(8'h00, 8'h18);
         rd_chk(8'h00, 8'h00);
      end
      // Writes are lost while the clock enable is low
      @(posedge clk_sys);
      ce <= 1'b0;
      host_u.wr(8'h01, 8'h00);
      ce <= 1'b1;
      rd_chk(8'h01, 8'h03);
      // Bias: always on, periodic scan, scan disabled
      host_u.wr(8'h04, 8'h00);
      host_u.wr(8'h03, 8'h60);
      tick(2);
      `CHK(thermistor_bias_output, 1'b1)
      for (int s = 0; s < 2; s++) begin
         host_u.wr(8'h03, s ? 8'h10 : 8'h20);
         @(posedge clk_sys);
         therm_low_cmp <= (s == 1);
         tick(2);
         cnt = 0;
         repeat (400) begin
            @(negedge clk_sys);
            cnt += int'(thermistor_bias_output);
         end
         `CHK(cnt, s ? 40 : 0)
      end
      rd_chk(8'h00, 8'h10);
      tick(2);
      end_sim();
   end
endmodule : tb
